// File: hdl/pump_station_timing_control.v
// pump station supervisory timers, signalling outputs and wishbone registers
`timescale 1ns/1ps
`include "pump_map.vh"

module pump_station_timing_control #(
  parameter CYC_PER_SEC = `CLK_HZ           // cycles per time base tick
) (
  input  wire        clk,                   // system clock, 10 MHz
  input  wire        sys_rst,               // synchronous reset, high
  input  wire        ce,                    // clock enable, freezes all registers
  input  wire        wb_cyc_i,              // wishbone cycle
  input  wire        wb_stb_i,              // wishbone strobe
  input  wire        wb_we_i,               // wishbone write
  input  wire [7:0]  wb_adr_i,              // wishbone byte address
  input  wire [3:0]  wb_sel_i,              // wishbone byte selects
  input  wire [31:0] wb_dat_i,              // wishbone write data
  output wire [31:0] wb_dat_o,              // wishbone read data
  output wire        wb_ack_o,              // wishbone acknowledge
  input  wire        unitReady,             // switchgear operational
  input  wire [1:0]  pumpRun,               // pump running feedback
  input  wire        feedReq,               // feed pump start request
  input  wire        dryIn,                 // raw dry-run condition
  input  wire        overPresIn,            // raw overpressure
  input  wire        underPresIn,           // raw underpressure
  input  wire        phaseErrIn,            // raw phase rotation error
  input  wire [1:0]  underCurIn,            // raw undercurrent per pump
  output wire        flushValveOut,         // fresh water flush valve
  output wire        scaleValveOut,         // anti-scaling valve open
  output wire        leadPumpOut,           // current lead pump index
  output wire        feedStartOut,          // feed pump start command
  output wire        auxOut,                // auxiliary pump output
  output wire        dryFaultOut,           // qualified dry-run fault
  output wire        presFaultOut,          // qualified pressure fault
  output wire        phaseFaultOut,         // phase rotation fault
  output wire        curFaultOut,           // undercurrent fault
  output wire        collective_run_out,    // collective run signal
  output wire        collective_fault_out   // collective fault signal
);

  // flush and valve state machines, one-hot
  localparam [1:0] F_WAIT = 2'b01;          // counting the interval
  localparam [1:0] F_OPEN = 2'b10;          // valve open

  // unsigned clamp used by the flush, cycle, delay and valve fields
  function [7:0] clampU;
    input [7:0] val;
    input [7:0] lo;
    input [7:0] hi;
    begin
      if (val < lo) begin
        clampU = lo;
      end else if (val > hi) begin
        clampU = hi;
      end else begin
        clampU = val;
      end
    end
  endfunction

  // qualification counter step: restart on clear, saturate at the limit
  function [7:0] qualNext;
    input [7:0] cnt;
    input       cond;
    input       tick;
    input [7:0] lim;
    begin
      if (!cond) begin
        qualNext = 8'h00;
      end else if (tick && cnt < lim) begin
        qualNext = cnt + 8'h01;
      end else begin
        qualNext = cnt;
      end
    end
  endfunction

  // configuration registers
  reg        runMode_ff;                    // 1 running mode, 0 ready
  reg        faultRise_ff;                  // 1 rising, 0 falling
  reg        phaseEn_ff;                    // phase detection enable
  reg        underCurEn_ff;                 // undercurrent enable
  reg [7:0]  flushDays_ff;                  // flush interval, days
  reg [7:0]  flushMin_ff;                   // flush duration, minutes
  reg [7:0]  cycHours_ff;                   // swap period, 0 is off
  reg [7:0]  drySec_ff;                     // dry-run delay, seconds
  reg [7:0]  presSec_ff;                    // pressure delay, seconds
  reg [7:0]  idleDays_ff;                   // valve idle interval, days
  reg [7:0]  openSec_ff;                    // valve open time, seconds
  reg [6:0]  auxSec_ff;                     // signed aux offset, seconds
  // bus registers
  reg        ack_ff;                        // acknowledge
  reg [31:0] rdat_ff;                       // read data
  // time base and timers
  reg [23:0] preCnt_ff;                     // cycle prescaler
  reg        secTick_ff;                    // one-cycle seconds tick
  reg [1:0]  flushSt_ff;                    // flush state
  reg [21:0] flushCnt_ff;                   // flush seconds counter
  reg [1:0]  valveSt_ff;                    // valve state
  reg [21:0] valveCnt_ff;                   // valve seconds counter
  reg [14:0] cycCnt_ff;                     // swap seconds counter
  reg        lead_ff;                       // lead pump
  reg [7:0]  dryCnt_ff;                     // dry-run qualifier
  reg [7:0]  presCnt_ff;                    // pressure qualifier
  reg [7:0]  auxCnt_ff;                     // seconds since feed request
  reg        dryFault_ff;                   // registered dry fault
  reg        presFault_ff;                  // registered pressure fault
  reg        runOut_ff;                     // registered run output
  reg        faultOut_ff;                   // registered fault output
  reg        feedStart_ff;                  // registered feed start
  reg        aux_ff;                        // registered aux output

  wire       wbReq    = wb_cyc_i & wb_stb_i & ~ack_ff; // new bus access
  wire       wrEn     = wbReq & wb_we_i & wb_sel_i[0];
  wire [7:0] wrByte   = wb_dat_i[7:0];      // fields take the low byte
  wire [7:0] wrByte1  = wb_dat_i[15:8];     // second field byte
  wire       anyRun   = |pumpRun;
  wire       auxNeg   = auxSec_ff[6];
  wire [7:0] auxMag   = auxNeg ? {1'b0, -auxSec_ff} : {1'b0, auxSec_ff};
  wire [21:0] flushLim = flushDays_ff[4:0] * `SEC_PER_DAY;
  wire [21:0] flushDur = flushMin_ff[3:0] * `SEC_PER_MIN;
  wire [21:0] idleLim  = idleDays_ff[2:0] * `SEC_PER_DAY;
  wire [21:0] cycProd  = cycHours_ff[2:0] * `SEC_PER_HOUR; // 21600 max
  wire [14:0] cycLim   = cycProd[14:0];     // six hours fits 15 bits
  wire       phaseFlt = phaseEn_ff & phaseErrIn;
  wire       curFlt   = underCurEn_ff & (|(underCurIn & pumpRun));
  wire       presIn   = overPresIn | underPresIn;
  wire       anyFault = dryFault_ff | presFault_ff | phaseFlt | curFlt;
  wire [7:0] dryNxt   = qualNext(dryCnt_ff, dryIn, secTick_ff, drySec_ff);
  wire [7:0] presNxt  = qualNext(presCnt_ff, presIn, secTick_ff,
                                 presSec_ff);
  wire [7:0] auxNxt   = qualNext(auxCnt_ff, feedReq, secTick_ff, auxMag);

  // bus slave: one-cycle ack, unmapped reads zero, writes clamp to range
  always @(posedge clk) begin
    if (sys_rst) begin
      ack_ff        <= 1'b0;
      rdat_ff       <= 32'h00000000;
      runMode_ff    <= `RST_RUNMODE;
      faultRise_ff  <= `RST_FLTRISE;
      phaseEn_ff    <= `RST_PHASEEN;
      underCurEn_ff <= `RST_UCUREN;
      flushDays_ff  <= `RST_FLUSHDAYS;
      flushMin_ff   <= `RST_FLUSHMIN;
      cycHours_ff   <= `RST_CYCHOURS;
      drySec_ff     <= `RST_DRYSEC;
      presSec_ff    <= `RST_PRESSEC;
      idleDays_ff   <= `RST_IDLEDAYS;
      openSec_ff    <= `RST_OPENSEC;
      auxSec_ff     <= `RST_AUXSEC;
    end else if (ce) begin
      ack_ff  <= wbReq;
      rdat_ff <= 32'h00000000;
      if (wrEn && wb_adr_i == `REG_CTRL) begin
        runMode_ff    <= wrByte[`CTRL_RUNMODE];
        faultRise_ff  <= wrByte[`CTRL_FLTRISE];
        phaseEn_ff    <= wrByte[`CTRL_PHASEEN];
        underCurEn_ff <= wrByte[`CTRL_UCUREN];
      end else if (wrEn && wb_adr_i == `REG_FLUSH) begin
        flushDays_ff <= clampU(wrByte, `FLUSHDAYS_MIN,
                               `FLUSHDAYS_MAX);
        if (wb_sel_i[1]) begin
          flushMin_ff <= clampU(wrByte1, `FLUSHMIN_MIN,
                                `FLUSHMIN_MAX);
        end
      end else if (wrEn && wb_adr_i == `REG_CYCLE) begin
        cycHours_ff <= clampU(wrByte, 8'h00, `CYCHOURS_MAX);
      end else if (wrEn && wb_adr_i == `REG_DRYDLY) begin
        drySec_ff <= clampU(wrByte, 8'h00, `DRYSEC_MAX);
      end else if (wrEn && wb_adr_i == `REG_PRESDLY) begin
        presSec_ff <= clampU(wrByte, `SEC60_MIN, `SEC60_MAX);
      end else if (wrEn && wb_adr_i == `REG_VALVE) begin
        idleDays_ff <= clampU(wrByte, 8'h00, `IDLEDAYS_MAX);
        if (wb_sel_i[1]) begin
          openSec_ff <= clampU(wrByte1, `SEC60_MIN, `SEC60_MAX);
        end
      end else if (wrEn && wb_adr_i == `REG_AUX) begin
        // signed range -60..+60, out-of-range values pinned to the bound
        if (wrByte[6] && wrByte[6:0] < `AUX_NEG_MIN) begin
          auxSec_ff <= `AUX_NEG_MIN;
        end else if (!wrByte[6] && wrByte[6:0] > `AUX_POS_MAX) begin
          auxSec_ff <= `AUX_POS_MAX;
        end else begin
          auxSec_ff <= wrByte[6:0];
        end
      end
      if (wbReq && !wb_we_i) begin
        if (wb_adr_i == `REG_CTRL) begin
          rdat_ff <= {28'h0000000, underCurEn_ff, phaseEn_ff,
                      faultRise_ff, runMode_ff};
        end else if (wb_adr_i == `REG_FLUSH) begin
          rdat_ff <= {16'h0000, flushMin_ff, flushDays_ff};
        end else if (wb_adr_i == `REG_CYCLE) begin
          rdat_ff <= {24'h000000, cycHours_ff};
        end else if (wb_adr_i == `REG_DRYDLY) begin
          rdat_ff <= {24'h000000, drySec_ff};
        end else if (wb_adr_i == `REG_PRESDLY) begin
          rdat_ff <= {24'h000000, presSec_ff};
        end else if (wb_adr_i == `REG_VALVE) begin
          rdat_ff <= {16'h0000, openSec_ff, idleDays_ff};
        end else if (wb_adr_i == `REG_AUX) begin
          rdat_ff <= {25'h000000, auxSec_ff};
        end else if (wb_adr_i == `REG_STATUS) begin
          rdat_ff <= {21'h00000, faultOut_ff, runOut_ff, aux_ff,
                      feedStart_ff, curFlt, phaseFlt, presFault_ff,
                      dryFault_ff, lead_ff, valveSt_ff[1],
                      flushSt_ff[1]};
        end
      end
    end
  end

  // seconds time base; all timers step on this tick only
  always @(posedge clk) begin
    if (sys_rst) begin
      preCnt_ff  <= 24'h000000;
      secTick_ff <= 1'b0;
    end else if (ce) begin
      if (preCnt_ff == CYC_PER_SEC[23:0] - 24'h000001) begin
        preCnt_ff  <= 24'h000000;
        secTick_ff <= 1'b1;
      end else begin
        preCnt_ff  <= preCnt_ff + 24'h000001;
        secTick_ff <= 1'b0;
      end
    end
  end

  // flush scheduler: wait the interval, then open for the duration
  always @(posedge clk) begin
    if (sys_rst) begin
      flushSt_ff  <= F_WAIT;
      flushCnt_ff <= 22'h000000;
    end else if (ce && secTick_ff) begin
      case (flushSt_ff)
        F_WAIT: begin
          if (flushCnt_ff + 22'h000001 >= flushLim) begin
            flushSt_ff  <= F_OPEN;
            flushCnt_ff <= 22'h000000;
          end else begin
            flushCnt_ff <= flushCnt_ff + 22'h000001;
          end
        end
        F_OPEN: begin
          if (flushCnt_ff + 22'h000001 >= flushDur) begin
            flushSt_ff  <= F_WAIT;
            flushCnt_ff <= 22'h000000;
          end else begin
            flushCnt_ff <= flushCnt_ff + 22'h000001;
          end
        end
        default: begin
          flushSt_ff  <= F_WAIT;
          flushCnt_ff <= 22'h000000;
        end
      endcase
    end
  end

  // anti-scaling valve: idle interval, then open; zero days disables it
  always @(posedge clk) begin
    if (sys_rst) begin
      valveSt_ff  <= F_WAIT;
      valveCnt_ff <= 22'h000000;
    end else if (ce && secTick_ff) begin
      case (valveSt_ff)
        F_WAIT: begin
          if (idleDays_ff == 8'h00) begin
            valveCnt_ff <= 22'h000000;
          end else if (valveCnt_ff + 22'h000001 >= idleLim) begin
            valveSt_ff  <= F_OPEN;
            valveCnt_ff <= 22'h000000;
          end else begin
            valveCnt_ff <= valveCnt_ff + 22'h000001;
          end
        end
        F_OPEN: begin
          if (valveCnt_ff[7:0] + 8'h01 >= openSec_ff) begin
            valveSt_ff  <= F_WAIT;
            valveCnt_ff <= 22'h000000;
          end else begin
            valveCnt_ff <= valveCnt_ff + 22'h000001;
          end
        end
        default: begin
          valveSt_ff  <= F_WAIT;
          valveCnt_ff <= 22'h000000;
        end
      endcase
    end
  end

  // lead pump rotation, counts only while a pump runs
  always @(posedge clk) begin
    if (sys_rst) begin
      cycCnt_ff <= 15'h0000;
      lead_ff   <= 1'b0;
    end else if (ce) begin
      if (cycHours_ff == 8'h00) begin
        cycCnt_ff <= 15'h0000;
      end else if (secTick_ff && anyRun) begin
        if (cycCnt_ff + 15'h0001 >= cycLim) begin
          cycCnt_ff <= 15'h0000;
          lead_ff   <= ~lead_ff;
        end else begin
          cycCnt_ff <= cycCnt_ff + 15'h0001;
        end
      end
    end
  end

  // fault qualifiers, aux offset and registered signalling outputs
  always @(posedge clk) begin
    if (sys_rst) begin
      dryCnt_ff    <= 8'h00;
      presCnt_ff   <= 8'h00;
      auxCnt_ff    <= 8'h00;
      dryFault_ff  <= 1'b0;
      presFault_ff <= 1'b0;
      runOut_ff    <= 1'b0;
      faultOut_ff  <= 1'b0;
      feedStart_ff <= 1'b0;
      aux_ff       <= 1'b0;
    end else if (ce) begin
      dryCnt_ff    <= dryNxt;
      presCnt_ff   <= presNxt;
      auxCnt_ff    <= auxNxt;
      // raised only once the condition held across as many seconds ticks as the delay
      dryFault_ff  <= dryIn && dryNxt >= drySec_ff;
      presFault_ff <= presIn && presNxt >= presSec_ff;
      runOut_ff    <= runMode_ff ? anyRun : unitReady;
      faultOut_ff  <= faultRise_ff ? anyFault : ~anyFault;
      if (auxNeg) begin
        aux_ff       <= feedReq;
        feedStart_ff <= feedReq && auxNxt >= auxMag;
      end else begin
        aux_ff       <= feedReq && auxNxt >= auxMag;
        feedStart_ff <= feedReq;
      end
    end
  end

  assign wb_dat_o             = rdat_ff;
  assign wb_ack_o             = ack_ff;
  assign flushValveOut        = flushSt_ff[1];
  assign scaleValveOut        = valveSt_ff[1];
  assign leadPumpOut          = lead_ff;
  assign feedStartOut         = feedStart_ff;
  assign auxOut               = aux_ff;
  assign dryFaultOut          = dryFault_ff;
  assign presFaultOut         = presFault_ff;
  assign phaseFaultOut        = phaseFlt;
  assign curFaultOut          = curFlt;
  assign collective_run_out   = runOut_ff;
  assign collective_fault_out = faultOut_ff;

endmodule // pump_station_timing_control

// File: hdl/pump_map.vh
// register offsets, field positions, reset values and timing for pump timing
`ifndef PUMP_MAP_VH
`define PUMP_MAP_VH
// register byte offsets
`define REG_CTRL      8'h00
`define REG_FLUSH     8'h04
`define REG_CYCLE     8'h08
`define REG_DRYDLY    8'h0C
`define REG_PRESDLY   8'h10
`define REG_VALVE     8'h14
`define REG_AUX       8'h18
`define REG_STATUS    8'h1C
// control bit positions
`define CTRL_RUNMODE  0
`define CTRL_FLTRISE  1
`define CTRL_PHASEEN  2
`define CTRL_UCUREN   3
// field positions
`define FLUSH_MIN_LSB 8
`define VALVE_SEC_LSB 8
// reset values
`define RST_RUNMODE   1'b1
`define RST_FLTRISE   1'b1
`define RST_PHASEEN   1'b1
`define RST_UCUREN    1'b1
`define RST_FLUSHDAYS 8'h15
`define RST_FLUSHMIN  8'h03
`define RST_CYCHOURS  8'h06
`define RST_DRYSEC    8'h0F
`define RST_PRESSEC   8'h05
`define RST_IDLEDAYS  8'h07
`define RST_OPENSEC   8'h03
`define RST_AUXSEC    7'h02
// value ranges
`define FLUSHDAYS_MIN 8'h07
`define FLUSHDAYS_MAX 8'h1F
`define FLUSHMIN_MIN  8'h01
`define FLUSHMIN_MAX  8'h09
`define CYCHOURS_MAX  8'h06
`define DRYSEC_MAX    8'hB4
`define SEC60_MIN     8'h01
`define SEC60_MAX     8'h3C
`define IDLEDAYS_MAX  8'h07
`define AUX_POS_MAX   7'h3C
`define AUX_NEG_MIN   7'h44
// timing
`define CLK_HZ        10000000
`define SEC_PER_MIN   22'h00003C
`define SEC_PER_HOUR  22'h000E10
`define SEC_PER_DAY   22'h015180
`endif

// File: tb/pump_station_checker.sv
// concurrent checks on the pump station timing block ports
`timescale 1ns/1ps
module pump_station_checker #(
  parameter CYC_PER_SEC = 2                  // cycles per tick
) (
  input wire logic        clk,               // clock
  input wire logic        sys_rst,           // sync reset
  input wire logic        ce,                // clock enable
  input wire logic        wb_cyc_i,          // bus cycle
  input wire logic        wb_stb_i,          // bus strobe
  input wire logic        wb_we_i,           // bus write
  input wire logic [7:0]  wb_adr_i,          // bus address
  input wire logic [31:0] wb_dat_o,          // read data
  input wire logic        wb_ack_o,          // bus answer
  input wire logic        unitReady,         // operational
  input wire logic [1:0]  pumpRun,           // pump feedback
  input wire logic        feedReq,           // feed request
  input wire logic        dryIn,             // raw dry run
  input wire logic        overPresIn,        // raw overpressure
  input wire logic        underPresIn,       // raw underpressure
  input wire logic        phaseErrIn,        // raw phase error
  input wire logic [1:0]  underCurIn,        // raw undercurrent
  input wire logic        leadPumpOut,       // lead pump
  input wire logic        auxOut,            // aux output
  input wire logic        dryFaultOut,       // dry fault
  input wire logic        presFaultOut,      // pressure fault
  input wire logic        phaseFaultOut,     // phase fault
  input wire logic        curFaultOut,       // current fault
  input wire logic        collective_run_out,  // run signal
  input wire logic        collective_fault_out // fault signal
);
  logic anyF;                                // any single fault
  logic presCond;                            // either pressure cond
  assign anyF = dryFaultOut | presFaultOut | phaseFaultOut | curFaultOut;
  assign presCond = overPresIn | underPresIn;
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);
  property p_ack_resp;
    wb_cyc_i && wb_stb_i && !wb_ack_o && ce |=> wb_ack_o;
  endproperty
  a_ack_resp: assert property (p_ack_resp) else $error("no ack");
  // unmapped places read as zero rather than aliasing a register
  property p_unmapped;
    wb_cyc_i && wb_stb_i && !wb_we_i && !wb_ack_o && ce
      && wb_adr_i > 8'h1F |=> wb_dat_o == 32'h0;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read");
  property p_run;
    collective_run_out |-> $past(pumpRun) != 2'b00 || $past(unitReady);
  endproperty
  a_run: assert property (p_run) else $error("run without cause");
  // bus writes may flip polarity, so a change right after one is exempt
  property p_fault;
    $changed(collective_fault_out) && !$past(sys_rst)
      && !$past(sys_rst, 2) && !$past(wb_ack_o)
      |-> $past(anyF) != $past(anyF, 2);
  endproperty
  a_fault: assert property (p_fault) else $error("fault edge");
  property p_dry;
    dryFaultOut |-> $past(dryIn);
  endproperty
  a_dry: assert property (p_dry) else $error("dry fault");
  // the first tick may fall on the cycle the condition appears
  property p_pres;
    presFaultOut |-> $past(presCond);
  endproperty
  a_pres: assert property (p_pres) else $error("pres fault");
  property p_pres_clr;
    !presCond |=> !presFaultOut;
  endproperty
  a_pres_clr: assert property (p_pres_clr) else $error("pres clear");
  property p_phase;
    phaseFaultOut |-> phaseErrIn;
  endproperty
  a_phase: assert property (p_phase) else $error("phase fault");
  property p_cur;
    curFaultOut |-> (underCurIn & pumpRun) != 2'b00;
  endproperty
  a_cur: assert property (p_cur) else $error("current fault");
  property p_aux;
    auxOut |-> $past(feedReq);
  endproperty
  a_aux: assert property (p_aux) else $error("aux without request");
  c_dry: cover property ($rose(dryFaultOut));
  c_aux: cover property ($rose(auxOut));
  c_lead: cover property ($changed(leadPumpOut));
  c_fault: cover property ($fell(collective_fault_out));
endmodule // pump_station_checker

bind pump_station_timing_control pump_station_checker #(
  .CYC_PER_SEC(CYC_PER_SEC)
) u_pump_station_checker (
  .clk(clk), .sys_rst(sys_rst), .ce(ce), .wb_cyc_i(wb_cyc_i),
  .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
  .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .unitReady(unitReady),
  .pumpRun(pumpRun), .feedReq(feedReq), .dryIn(dryIn),
  .overPresIn(overPresIn), .underPresIn(underPresIn),
  .phaseErrIn(phaseErrIn), .underCurIn(underCurIn),
  .leadPumpOut(leadPumpOut), .auxOut(auxOut), .dryFaultOut(dryFaultOut),
  .presFaultOut(presFaultOut), .phaseFaultOut(phaseFaultOut),
  .curFaultOut(curFaultOut), .collective_run_out(collective_run_out),
  .collective_fault_out(collective_fault_out)
);

// File: tb/pump_field_model.sv
// field model: pumps follow the start command and the lead choice
`timescale 1ns/1ps
module pump_field_model (
  input  wire logic       clk,           // system clock
  input  wire logic       sys_rst,       // sync reset
  input  wire logic       feedStartOut,  // start command
  input  wire logic       leadPumpOut,   // lead pump index
  output logic      [1:0] pumpRun        // run feedback
);
  // contactor feedback lags the command by one clock
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      pumpRun <= 2'h0;
    end else if (feedStartOut) begin
      pumpRun <= leadPumpOut ? 2'h2 : 2'h1;
    end else begin
      pumpRun <= 2'h0;
    end
  end
endmodule // pump_field_model

// File: tb/test_pump_station_timing_control.sv
// self-checking bench for the pump station timing block
`timescale 1ns/1ps
module test_pump_station_timing_control;
  localparam int CPS = 2;                // short tick for simulation
  logic        clk, sysRst, ce;          // clock, reset, enable
  logic        cyc, stb, we, ack;        // bus control
  logic [7:0]  adr;                      // bus address
  logic [3:0]  sel;                      // byte selects
  logic [31:0] datI, datO, rd;           // bus data
  logic        unitReady, feedReq;       // station inputs
  logic        dryIn, overPresIn, underPresIn, phaseErrIn; // raw
  logic [1:0]  underCurIn, pumpRun;      // current, pumps
  logic        flushV, scaleV, lead, feedStart, aux; // actuators
  logic        dryF, presF, phaseF, curF, runOut, faultOut; // signals
  int          fails, checks;            // counters
  pump_station_timing_control #(.CYC_PER_SEC(CPS))
  u_pump_station_timing_control (
    .clk(clk), .sys_rst(sysRst), .ce(ce), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(datI),
    .wb_dat_o(datO), .wb_ack_o(ack), .unitReady(unitReady),
    .pumpRun(pumpRun), .feedReq(feedReq), .dryIn(dryIn),
    .overPresIn(overPresIn), .underPresIn(underPresIn),
    .phaseErrIn(phaseErrIn), .underCurIn(underCurIn),
    .flushValveOut(flushV), .scaleValveOut(scaleV), .leadPumpOut(lead),
    .feedStartOut(feedStart), .auxOut(aux), .dryFaultOut(dryF),
    .presFaultOut(presF), .phaseFaultOut(phaseF), .curFaultOut(curF),
    .collective_run_out(runOut), .collective_fault_out(faultOut));
  pump_field_model u_pump_field_model (
    .clk(clk), .sys_rst(sysRst), .feedStartOut(feedStart),
    .leadPumpOut(lead), .pumpRun(pumpRun));
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      fails++;
      $display("wrong value %s expected %0h seen %0h", nm, exp, seen);
    end
  endtask
  task end_of_test;
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  // a wait ran out: count it and close the run
  task stuck;
    fails++;
    end_of_test;
  endtask
  // one classic cycle, held until ack is sampled high
  task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    int k;
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    datI <= d;
    k = 0;
    do begin
      @(posedge clk);
      k++;
    end while (ack !== 1'b1 && k < 20);
    rd = datO;
    if (k >= 20) stuck;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask
  // cycles until the chosen output goes high, bounded
  task measure(input int s, output int n);
    logic v;
    n = 0;
    do begin
      @(posedge clk);
      #1;
      n++;
      v = s == 0 ? dryF : s == 1 ? presF : s == 2 ? aux : s == 3 ? feedStart : lead;
    end while (v !== 1'b1 && n < 9000);
    if (n >= 9000) stuck;
  endtask
  task setc(input int s, input logic v);
    case (s)
      0: dryIn <= v;
      1: overPresIn <= v;
      default: underPresIn <= v;
    endcase
  endtask
  task t_regs;
    logic [7:0]  a [12] = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h10, 8'h14,
      8'h18, 8'h04, 8'h04, 8'h0C, 8'h10, 8'h18};
    logic [31:0] w [12] = '{0, 0, 0, 0, 0, 0, 0, 32'h0A40, 32'h0, 32'hFF,
      32'h3D, 32'h43};
    logic [31:0] e [12] = '{32'h0F, 32'h0315, 32'h06, 32'h0F, 32'h05,
      32'h0307, 32'h02, 32'h091F, 32'h0107, 32'hB4, 32'h3C, 32'h44};
    for (int i = 0; i < 12; i++) begin
      if (i > 6) bus(1'b1, a[i], w[i]);
      bus(1'b0, a[i], 32'h0);
      chk("register", rd, e[i]);
    end
    bus(1'b1, 8'h40, 32'hFFFF);
    bus(1'b0, 8'h40, 32'h0);
    chk("unmapped", rd, 32'h0);
    bus(1'b1, 8'h1C, 32'h07FF);
    bus(1'b0, 8'h1C, 32'h0);
    chk("status", rd, 32'h0);
    $display("t_regs done");
  endtask
  task t_swap;
    int n;
    bus(1'b1, 8'h18, 32'h00);
    bus(1'b1, 8'h08, 32'h01);
    feedReq <= 1'b1;
    measure(4, n);
    chk("swapTime", n >= 3599 * CPS && n <= 3600 * CPS + 6, 1);
    bus(1'b1, 8'h08, 32'h00);
    repeat (3600 * CPS + 50) @(posedge clk);
    chk("swapOff", {lead, pumpRun}, 3'h6);
    chk("valves", {flushV, scaleV}, 2'h0);
    feedReq <= 1'b0;
    $display("t_swap done");
  endtask
  task t_qual(input int s, input int nd);
    int n;
    bus(1'b1, s == 0 ? 8'h0C : 8'h10, nd);
    if (nd > 1) begin
      setc(s, 1'b1);
      repeat ((nd - 1) * CPS) @(posedge clk);
      setc(s, 1'b0);
      @(posedge clk);
      setc(s, 1'b1);
      repeat ((nd - 1) * CPS) @(posedge clk);
      chk("restart", {dryF, presF}, 2'h0);
      setc(s, 1'b0);
      repeat (2) @(posedge clk);
    end
    setc(s, 1'b1);
    measure(s == 0 ? 0 : 1, n);
    chk("delay", n >= (nd - 1) * CPS + 1 && n <= nd * CPS + 2, 1);
    setc(s, 1'b0);
    repeat (3) @(posedge clk);
    chk("cleared", {dryF, presF}, 2'h0);
    $display("t_qual done");
  endtask
  task t_aux(input logic [6:0] off);
    int n, m;
    m = off[6] ? 128 - off : off;
    bus(1'b1, 8'h18, off);
    feedReq <= 1'b1;
    measure(off[6] ? 3 : 2, n);
    chk("auxDelay", n >= (m - 1) * CPS + 1 && n <= m * CPS + 2, 1);
    chk("auxOther", {aux, feedStart}, 2'h3);
    feedReq <= 1'b0;
    repeat (4) @(posedge clk);
    $display("t_aux done");
  endtask
  task t_run;
    repeat (3) @(posedge clk);
    chk("runIdle", runOut, 1'b0);
    feedReq <= 1'b1;
    repeat (4) @(posedge clk);
    chk("runPump", runOut, 1'b1);
    bus(1'b1, 8'h00, 32'h0E);
    unitReady <= 1'b0;
    repeat (3) @(posedge clk);
    chk("readyOff", runOut, 1'b0);
    unitReady <= 1'b1;
    repeat (3) @(posedge clk);
    chk("readyOn", runOut, 1'b1);
    $display("t_run done");
  endtask
  task t_fault;
    bus(1'b1, 8'h00, 32'h0F);
    phaseErrIn <= 1'b1;
    repeat (3) @(posedge clk);
    chk("phaseRise", {phaseF, faultOut}, 2'h3);
    bus(1'b1, 8'h00, 32'h0D);
    phaseErrIn <= 1'b0;
    repeat (3) @(posedge clk);
    chk("fallIdle", faultOut, 1'b1);
    phaseErrIn <= 1'b1;
    repeat (3) @(posedge clk);
    chk("fallFault", faultOut, 1'b0);
    bus(1'b1, 8'h00, 32'h0B);
    repeat (3) @(posedge clk);
    chk("phaseOff", {phaseF, faultOut}, 2'h0);
    underCurIn <= 2'h2;
    repeat (3) @(posedge clk);
    chk("curOn", {curF, faultOut}, 2'h3);
    bus(1'b1, 8'h00, 32'h03);
    repeat (3) @(posedge clk);
    chk("curOff", {curF, faultOut}, 2'h0);
    $display("t_fault done");
  endtask
  initial begin
    {cyc, stb, we, adr, datI, feedReq, dryIn, overPresIn} = 0;
    {underPresIn, phaseErrIn, underCurIn, fails, checks} = 0;
    {sysRst, ce, unitReady, sel} = 7'h7F;
    repeat (4) @(posedge clk);
    sysRst <= 1'b0;
    t_regs;
    t_swap;
    t_qual(0, 0);
    t_qual(0, 180);
    t_qual(1, 60);
    t_qual(2, 1);
    t_aux(7'h44);
    t_aux(7'h02);
    t_aux(7'h3C);
    t_run;
    t_fault;
    end_of_test;
  end
endmodule // test_pump_station_timing_control
